// [hw/csc_serial_control.sv]
// Control sequencer of the codec: control bytes, conversions and readout.
`timescale 1ns/100ps
module csc_serial_control #(
	parameter int CONV_CYCLES = csc_pkg::CONV_CYCLES
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic serial_in,
	input wire logic signed [csc_pkg::RAW_W-1:0] analog_input_code,
	input wire logic signed [csc_pkg::RAW_W-1:0] half_supply_code,
	output logic serial_out,
	output logic serial_out_en,
	output logic track_hold,
	output logic [7:0] dac_code,
	output logic dac_power,
	output logic adc_power,
	output logic ref_power,
	output logic supply_sense_select
);
	// ==========================================================
	// Register state of the sequencer.
	typedef struct packed {
		csc_pkg::csc_state_t state;
		logic cs_s1;
		logic cs_s2;
		logic cs_s3;
		logic rt_s1;
		logic rt_s2;
		logic rt_s3;
		logic ft_s1;
		logic ft_s2;
		logic ft_s3;
		logic [3:0] cnt;
		logic [7:0] rx;
		logic ref_enable_bit;
		logic adc_enable_bit;
		logic dac_enable_bit;
		logic dac_select_bit;
		logic adc_select_bit;
		logic supply_sense_select;
		logic continuous_mode_bit;
		logic [7:0] dac_reg;
		logic [7:0] result;
		logic [15:0] conv_cnt;
		logic hold;
		logic sout;
		logic sout_en;
	} csc_reg_t;

	csc_reg_t s_reg;
	csc_reg_t s_next;
	logic rise_tgl;
	logic rise_bit;
	logic fall_tgl;
	logic cs_high;
	logic cs_rise;
	logic rise_ev;
	logic fall_ev;
	logic [7:0] rx_shift;
	logic [3:0] cnt_inc;

	// ==========================================================
	// Link front end on the serial clock.
	csc_link u_link (
		.sclk(sclk),
		.reset(reset),
		.cs_n(cs_n),
		.serial_in(serial_in),
		.rise_tgl(rise_tgl),
		.rise_bit(rise_bit),
		.fall_tgl(fall_tgl)
	);

	// ==========================================================
	// Functions.

	// Power-on state: everything off, DAC register cleared, syncs kept.
	function automatic csc_reg_t csc_por(input csc_reg_t s);
		csc_reg_t t;
		t = '0;
		t.state = csc_pkg::ST_HUNT;
		t.dac_reg = csc_pkg::DAC_RESET_CODE; // [R20]
		t.cs_s1 = s.cs_s1;
		t.cs_s2 = s.cs_s2;
		t.cs_s3 = s.cs_s3;
		t.rt_s1 = s.rt_s1;
		t.rt_s2 = s.rt_s2;
		t.rt_s3 = s.rt_s3;
		t.ft_s1 = s.ft_s1;
		t.ft_s2 = s.ft_s2;
		t.ft_s3 = s.ft_s3;
		return t;
	endfunction : csc_por

	// Takes a full control byte and picks the next state from it.
	function automatic csc_reg_t csc_ctl_apply(input csc_reg_t s, input logic [7:0] b);
		csc_reg_t t;
		logic go;
		t = s;
		t.dac_select_bit = b[csc_pkg::DAC_SEL_POS]; // [R2]
		t.adc_select_bit = b[csc_pkg::ADC_SEL_POS];
		t.supply_sense_select = b[csc_pkg::SENSE_POS];
		t.continuous_mode_bit = b[csc_pkg::CONT_POS];
		t.ref_enable_bit = b[csc_pkg::REF_EN_POS]; // [R23]
		t.adc_enable_bit = b[csc_pkg::ADC_EN_POS];
		t.dac_enable_bit = b[csc_pkg::DAC_EN_POS]; // [R25]
		t.cnt = 4'h0;
		t.rx = 8'h00;
		// A conversion starts only once the ADC was already awake and the
		// input selection stays put; otherwise this byte just wakes or
		// switches the input and leaves the sampler tracking.
		go = b[csc_pkg::ADC_SEL_POS] && b[csc_pkg::ADC_EN_POS] && s.adc_enable_bit
			&& (b[csc_pkg::SENSE_POS] == s.supply_sense_select); // [R21] [R4]
		if (go) begin
			t.state = csc_pkg::ST_ARM; // [R8]
		end else if (b[csc_pkg::DAC_SEL_POS]) begin
			t.state = csc_pkg::ST_DDATA; // [R3]
		end else begin
			t.state = csc_pkg::ST_HUNT;
		end
		return t;
	endfunction : csc_ctl_apply

	// Limits a raw converter sample to the plain binary code range.
	function automatic logic [7:0] csc_clamp(input logic signed [csc_pkg::RAW_W-1:0] v);
		logic [7:0] c;
		c = csc_pkg::CODE_MIN;
		if (v < 0) begin
			c = csc_pkg::CODE_MIN; // [R22]
		end else if (v > csc_pkg::RAW_FULL_SCALE) begin
			c = csc_pkg::CODE_MAX; // [R22]
		end else begin
			c = v[7:0];
		end
		return c;
	endfunction : csc_clamp

	// ==========================================================
	// Event decode from the synchronised link signals.
	assign cs_high = s_reg.cs_s2;
	assign cs_rise = s_reg.cs_s2 && !s_reg.cs_s3;
	assign rise_ev = s_reg.rt_s2 != s_reg.rt_s3;
	assign fall_ev = s_reg.ft_s2 != s_reg.ft_s3;
	assign rx_shift = {s_reg.rx[6:0], rise_bit};
	assign cnt_inc = s_reg.cnt + 4'h1;

	// ==========================================================
	// Next-state logic.
	always_comb begin
		s_next = s_reg;

		// Three flops on chip select and on both link toggles; the third marks edges.
		s_next.cs_s1 = cs_n;
		s_next.cs_s2 = s_reg.cs_s1;
		s_next.cs_s3 = s_reg.cs_s2;
		s_next.rt_s1 = rise_tgl;
		s_next.rt_s2 = s_reg.rt_s1;
		s_next.rt_s3 = s_reg.rt_s2;
		s_next.ft_s1 = fall_tgl;
		s_next.ft_s2 = s_reg.ft_s1;
		s_next.ft_s3 = s_reg.ft_s2;

		case (s_reg.state)
			// Leading zeros are dropped; a one opens a control byte.
			csc_pkg::ST_HUNT: begin
				if (rise_ev && rise_bit) begin
					s_next.state = csc_pkg::ST_CTRL; // [R1]
					s_next.rx = 8'h01;
					s_next.cnt = 4'h1;
				end
			end

			// Remaining seven control bits, MSB first.
			csc_pkg::ST_CTRL: begin
				if (rise_ev) begin
					s_next.rx = rx_shift;
					s_next.cnt = cnt_inc;
					if (cnt_inc == csc_pkg::BYTE_BITS) begin
						s_next = csc_ctl_apply(s_next, rx_shift); // [R1]
					end
				end
			end

			// DAC data byte; the output moves after its eighth bit.
			csc_pkg::ST_DDATA: begin
				if (rise_ev) begin
					s_next.rx = rx_shift;
					s_next.cnt = cnt_inc;
					if (cnt_inc == csc_pkg::BYTE_BITS) begin
						s_next.dac_reg = rx_shift; // [R3] [R25]
						s_next.cnt = 4'h0;
						if (s_reg.continuous_mode_bit) begin
							s_next.state = csc_pkg::ST_DDATA; // [R12] [R6]
						end else begin
							s_next.state = csc_pkg::ST_HUNT; // [R5]
						end
					end
				end
			end

			// Waiting for the falling edge that closes the byte.
			csc_pkg::ST_ARM: begin
				if (fall_ev) begin
					s_next.state = csc_pkg::ST_CONV; // [R8] [R14]
					s_next.hold = 1'b1;
					s_next.conv_cnt = 16'h0000;
					s_next.result = s_reg.supply_sense_select ?
						csc_clamp(half_supply_code) : csc_clamp(analog_input_code);
				end
			end

			// Conversion in progress; clock edges here are not expected.
			csc_pkg::ST_CONV: begin
				s_next.conv_cnt = s_reg.conv_cnt + 16'h0001; // [R9]
				if (s_reg.conv_cnt == 16'(CONV_CYCLES - 1)) begin
					s_next.state = csc_pkg::ST_READ; // [R10]
					s_next.hold = 1'b0; // [R10]
					s_next.cnt = 4'h0;
					s_next.rx = 8'h00;
					s_next.sout = s_reg.result[7]; // [R26]
				end
			end

			// Result shift-out; data clocked in meanwhile is kept too.
			csc_pkg::ST_READ: begin
				if (fall_ev && (s_reg.cnt != 4'h0) && (s_reg.cnt < csc_pkg::BYTE_BITS)) begin
					s_next.sout = s_reg.result[6]; // [R26]
					s_next.result = {s_reg.result[6:0], 1'b0};
				end
				if (rise_ev) begin
					s_next.rx = rx_shift;
					s_next.cnt = cnt_inc;
					if (cnt_inc == csc_pkg::BYTE_BITS) begin
						if (s_reg.dac_select_bit) begin
							s_next.dac_reg = rx_shift; // [R12]
						end
						if (!s_reg.continuous_mode_bit) begin
							s_next.state = csc_pkg::ST_HUNT; // [R5]
						end else if (!s_reg.dac_select_bit && rx_shift[csc_pkg::START_POS]) begin
							s_next = csc_ctl_apply(s_next, rx_shift); // [R15]
						end else if (s_reg.adc_enable_bit) begin
							s_next.state = csc_pkg::ST_ARM; // [R14] [R6]
							s_next.cnt = 4'h0;
						end else begin
							s_next.state = csc_pkg::ST_HUNT;
						end
					end
				end
			end

			default: begin
				s_next.state = csc_pkg::ST_HUNT;
			end
		endcase

		// Chip select rising cuts off a control or DAC data byte being received.
		if (cs_rise) begin
			case (s_reg.state)
				csc_pkg::ST_CTRL: begin
					s_next = csc_por(s_next); // [R16] [R18]
				end
				csc_pkg::ST_DDATA: begin
					s_next.state = csc_pkg::ST_HUNT; // [R13] [R17] [R18]
					s_next.cnt = 4'h0;
					s_next.rx = 8'h00;
					s_next.dac_reg = s_reg.dac_reg; // [R17]
				end
				default: begin
					s_next.state = s_next.state; // [R19]
				end
			endcase
		end

		// The data pin is driven only during readout with a selected chip.
		s_next.sout_en = (s_next.state == csc_pkg::ST_READ) && !cs_high; // [R19]
	end

	// ==========================================================
	// State register.
	always_ff @(posedge clk) begin
		if (reset) begin
			s_reg <= '0; // [R20]
		end else begin
			s_reg <= s_next;
		end
	end

	// ==========================================================
	// Outputs, each straight from the state register.
	assign serial_out = s_reg.sout;
	assign serial_out_en = s_reg.sout_en;
	assign track_hold = s_reg.hold;
	assign dac_code = s_reg.dac_reg;
	assign dac_power = s_reg.dac_enable_bit; // [R23]
	assign adc_power = s_reg.adc_enable_bit; // [R23]
	assign ref_power = s_reg.ref_enable_bit; // [R23]
	assign supply_sense_select = s_reg.supply_sense_select;
endmodule : csc_serial_control

// [pkg/csc_pkg.sv]
// Constants, states and behaviour notes for the codec serial control block.
// Notes on behaviour
// [R1] Skip leading zeros; first one begins control.
// [R2] Control byte: start, selects, sense, mode, enables.
// [R3] DAC select: next byte loads DAC register.
// [R4] Host enables ADC, waits, then starts conversion.
// [R5] Single mode: new control byte per conversion.
// [R6] Continuous mode keeps configuration between conversions.
// [R7] Host uses one mode for both converters.
// [R8] Fall after control byte starts ADC conversion.
// [R9] Host stops serial clock during conversion.
// [R10] Conversion end: track again, shift result out.
// [R11] Host allows acquisition time before next conversion.
// [R12] DAC continuous: every byte updates DAC output.
// [R13] Chip select toggle ends DAC continuous mode.
// [R14] ADC continuous: eighth result fall restarts conversion.
// [R15] ADC-only continuous: start marker byte reconfigures.
// [R16] Partial control byte interrupted: full shutdown reset.
// [R17] Interrupted DAC data discarded, register kept.
// [R18] After interruption a new control byte needed.
// [R19] Readout paused by chip select, resumed later.
// [R20] Reset: full shutdown, DAC register cleared.
// [R21] Host changes sense with two control bytes.
// [R22] Result clamped to binary range 0 to 255.
// [R23] Enable bits power sections independently.
// [R24] Host waits wake-up time after enabling converters.
// [R25] DAC data loads while DAC powered down.
// [R26] Result MSB first, changed on falling edges.
package csc_pkg;
	// ==========================================================
	// Control byte field positions.
	localparam int START_POS = 7;
	localparam int DAC_SEL_POS = 6;
	localparam int ADC_SEL_POS = 5;
	localparam int SENSE_POS = 4;
	localparam int CONT_POS = 3;
	localparam int REF_EN_POS = 2;
	localparam int ADC_EN_POS = 1;
	localparam int DAC_EN_POS = 0;

	// ==========================================================
	// Widths, counts and reset values.
	localparam int RAW_W = 10;
	localparam logic [3:0] BYTE_BITS = 4'h8;
	localparam logic [7:0] DAC_RESET_CODE = 8'h00;
	localparam logic [7:0] CODE_MIN = 8'h00;
	localparam logic [7:0] CODE_MAX = 8'hFF;
	localparam logic signed [RAW_W-1:0] RAW_FULL_SCALE = 10'sh0FF;

	// ==========================================================
	// Timing.
	localparam int CLK_PERIOD_NS = 4;
	localparam int CONV_TIME_NS = 36000;
	localparam int CONV_CYCLES = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// ==========================================================
	// Sequencer states.
	typedef enum logic [2:0] {
		ST_HUNT,
		ST_CTRL,
		ST_DDATA,
		ST_ARM,
		ST_CONV,
		ST_READ
	} csc_state_t;
endpackage : csc_pkg

// [hw/csc_link.sv]
// Serial clock domain front end: samples data and marks clock edges.
`timescale 1ns/100ps
module csc_link (
	input wire logic sclk,
	input wire logic reset,
	input wire logic cs_n,
	input wire logic serial_in,
	output logic rise_tgl,
	output logic rise_bit,
	output logic fall_tgl
);
	// ==========================================================
	// State on the rising serial clock edge.
	typedef struct packed {
		logic tgl;
		logic dat;
	} csc_rise_t;

	csc_rise_t rise_reg;
	csc_rise_t rise_next;
	logic fall_reg;

	// Each rising edge inside a frame flips the toggle and holds the bit.
	always_comb begin
		rise_next = rise_reg;
		if (!cs_n) begin
			rise_next.tgl = ~rise_reg.tgl;
			rise_next.dat = serial_in;
		end
	end

	// The serial clock may stop at any time, so reset acts without it.
	always_ff @(posedge sclk or posedge reset) begin
		if (reset) begin
			rise_reg <= '0;
		end else begin
			rise_reg <= rise_next;
		end
	end

	// Each falling edge inside a frame flips a second toggle.
	always_ff @(negedge sclk or posedge reset) begin
		if (reset) begin
			fall_reg <= 1'b0;
		end else if (!cs_n) begin
			fall_reg <= ~fall_reg; // [R26]
		end
	end

	assign rise_tgl = rise_reg.tgl;
	assign rise_bit = rise_reg.dat;
	assign fall_tgl = fall_reg;
endmodule : csc_link

// [dv/csc_serial_control_asserts.sv]
// Concurrent checks on the ports of the codec serial control block.
`timescale 1ns/100ps
module csc_serial_control_asserts #(
	parameter int CONV_CYCLES = 20
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic serial_in,
	input wire logic signed [csc_pkg::RAW_W-1:0] analog_input_code,
	input wire logic signed [csc_pkg::RAW_W-1:0] half_supply_code,
	input wire logic serial_out,
	input wire logic serial_out_en,
	input wire logic track_hold,
	input wire logic [7:0] dac_code,
	input wire logic dac_power,
	input wire logic adc_power,
	input wire logic ref_power,
	input wire logic supply_sense_select
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);
	logic [15:0] hold_reg;
	logic [15:0] hold_next;

	// ==========================================
	// Hold length counter, cleared whenever the converter tracks.
	always_comb hold_next = track_hold ? hold_reg + 16'h0001 : 16'h0000;
	always_ff @(posedge clk) hold_reg <= reset ? 16'h0000 : hold_next;

	// ==========================================
	// Port relations.
	hold_len_a: assert property (
		$fell(track_hold) |-> hold_reg >= CONV_CYCLES && hold_reg <= CONV_CYCLES + 1)
		else $error("conversion hold length wrong");
	pin_off_a: assert property (cs_n [*6] |-> !serial_out_en)
		else $error("data pin driven while deselected");
	hold_start_a: assert property ($rose(track_hold) |-> !sclk && !cs_n)
		else $error("hold began away from a falling serial clock");
	dac_edge_a: assert property ($changed(dac_code) |-> sclk || cs_n)
		else $error("converter code changed outside a data byte end");
	reset_state_a: assert property (
		$fell(reset) |-> dac_code == 8'h00 && !dac_power && !adc_power && !ref_power)
		else $error("power-on state wrong");
	pin_on_a: assert property ($fell(track_hold) && !cs_n |-> ##[0:1] serial_out_en)
		else $error("result not presented after conversion");
	out_edge_a: assert property (
		serial_out_en && $past(serial_out_en) && $changed(serial_out) |-> !sclk)
		else $error("result bit changed while serial clock high");
	hold_power_a: assert property (track_hold |-> adc_power)
		else $error("conversion with converter powered down");
	sense_stable_a: assert property (track_hold |-> $stable(supply_sense_select))
		else $error("input select moved during conversion");
endmodule : csc_serial_control_asserts

// [dv/csc_spi_host.sv]
// Serial host model that drives frames and collects result bytes.
`timescale 1ns/100ps
module csc_spi_host (
	output logic sclk,
	output logic cs_n,
	output logic serial_in,
	input wire logic serial_out,
	input wire logic serial_out_en,
	output logic [7:0] rx_byte,
	output logic [7:0] rx_cnt
);
	int nb = 0;

	// Idle levels: clock low and still, chip deselected.
	initial begin
		sclk = 1'b0;
		cs_n = 1'b1;
		serial_in = 1'b0;
		rx_byte = 8'h00;
		rx_cnt = 8'h00;
	end

	// Chip select edges stay half a clock period clear of clock edges.
	task automatic sel(input logic on);
		#32 cs_n = ~on;
		if (!on) serial_in = ~serial_in; // A released line shows no stale level.
		#32;
	endtask : sel

	// Shifts n bits MSB first; the clock stops between calls.
	// Serial clock edges sit off the system clock edges; each bit takes 64 ns.
	task automatic shift(input int n, input logic [7:0] v);
		for (int i = n - 1; i >= 0; i--) begin
			serial_in = v[i];
			#31.3 sclk = 1'b1;
			if (serial_out_en === 1'b1) begin
				rx_byte = {rx_byte[6:0], serial_out};
				nb++;
				if (nb == 8) begin
					nb = 0;
					rx_cnt++;
				end
			end
			#32 sclk = 1'b0;
			#0.7;
		end
	endtask : shift
endmodule : csc_spi_host

// [dv/tb_top.sv]
// Self-checking bench for the codec serial control block.
`timescale 1ns/100ps
module tb_top;
	localparam int CONV_CYCLES = 20;
	logic clk = 1'b0;
	logic reset;
	logic sclk;
	logic cs_n;
	logic serial_in;
	logic signed [csc_pkg::RAW_W-1:0] analog_input_code;
	logic signed [csc_pkg::RAW_W-1:0] half_supply_code;
	logic serial_out;
	logic serial_out_en;
	logic track_hold;
	logic [7:0] dac_code;
	logic dac_power;
	logic adc_power;
	logic ref_power;
	logic supply_sense_select;
	logic [7:0] rx_byte;
	logic [7:0] rx_cnt;
	logic [7:0] exp_q[$];
	logic [7:0] d;
	logic signed [9:0] v;
	int err_count = 0;
	int check_count = 0;

	always #2 clk = ~clk;

	csc_serial_control #(.CONV_CYCLES(CONV_CYCLES)) dut (
		.clk(clk),
		.reset(reset),
		.sclk(sclk),
		.cs_n(cs_n),
		.serial_in(serial_in),
		.analog_input_code(analog_input_code),
		.half_supply_code(half_supply_code),
		.serial_out(serial_out),
		.serial_out_en(serial_out_en),
		.track_hold(track_hold),
		.dac_code(dac_code),
		.dac_power(dac_power),
		.adc_power(adc_power),
		.ref_power(ref_power),
		.supply_sense_select(supply_sense_select)
	);

	// Serial host at the far side of the link.
	csc_spi_host host (
		.sclk(sclk),
		.cs_n(cs_n),
		.serial_in(serial_in),
		.serial_out(serial_out),
		.serial_out_en(serial_out_en),
		.rx_byte(rx_byte),
		.rx_cnt(rx_cnt)
	);

	// ==========================================
	// Comparison, verdict and expected-code helpers.
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		check_count++;
		if (got !== exp) begin
			err_count++;
			$display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk

	task automatic tally_and_finish();
		$display("checks %0d errors %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : tally_and_finish

	function automatic logic [7:0] clamp(input logic signed [9:0] r);
		return (r < 0) ? 8'h00 : (r > 10'sh0FF) ? 8'hFF : r[7:0];
	endfunction : clamp

	task automatic wait_th(input logic lvl);
		int k;
		k = 0;
		while (track_hold !== lvl && k < 500) begin
			@(negedge clk);
			k++;
		end
		chk(track_hold, lvl);
	endtask : wait_th

	// One conversion; the readout is split by a deselect in mid-byte.
	task automatic conv(input logic [7:0] c, input logic [7:0] e);
		repeat (4) @(negedge clk);
		host.sel(1'b1);
		host.shift(8, c);
		wait_th(1'b1);
		wait_th(1'b0);
		exp_q.push_back(e);
		host.shift(4, 8'h00);
		host.sel(1'b0);
		chk(serial_out_en, 1'b0);
		host.sel(1'b1);
		host.shift(4, 8'h00);
		host.sel(1'b0);
	endtask : conv

	// Each collected result byte is compared with the oldest note.
	always @(rx_cnt) if (rx_cnt !== 8'h00) chk(rx_byte, exp_q.pop_front());

	// ==========================================
	// Main sequence.
	initial begin
		reset <= 1'b1;
		analog_input_code <= 10'sh000;
		half_supply_code <= 10'sh000;
		void'($urandom(95));
		repeat (12) @(posedge clk);
		reset <= 1'b0;
		repeat (4) @(posedge clk);
		@(negedge clk);
		chk({dac_code, dac_power, adc_power, ref_power, track_hold, serial_out_en}, 16'h0000);
		host.sel(1'b1);
		host.shift(3, 8'h00);
		host.shift(8, 8'hA6);
		host.sel(1'b0);
		chk({adc_power, ref_power, dac_power, track_hold}, 16'h000C);
		// Let the converter and reference wake before the first conversion.
		repeat (25) @(negedge clk);
		for (int i = 0; i < 3; i++) begin
			v = (i == 0) ? 10'($urandom_range(255)) : (i == 1) ? 10'sh3FB : 10'sh12C;
			@(posedge clk) analog_input_code <= v;
			@(negedge clk);
			conv(8'hA6, clamp(v));
		end
		v = 10'($urandom_range(255));
		@(posedge clk) half_supply_code <= v;
		@(negedge clk);
		host.sel(1'b1);
		host.shift(8, 8'hB6);
		host.sel(1'b0);
		chk({supply_sense_select, track_hold}, 16'h0002);
		conv(8'hB6, clamp(v));
		d = 8'($urandom);
		host.sel(1'b1);
		host.shift(8, 8'hC6);
		host.shift(8, d);
		host.sel(1'b0);
		chk({dac_code, dac_power}, {d, 1'b0});
		host.sel(1'b1);
		host.shift(8, 8'hCF);
		for (int i = 0; i < 3; i++) begin
			d = 8'($urandom);
			host.shift(8, d);
			chk({dac_code, dac_power}, {d, 1'b1});
		end
		host.shift(4, 8'h0F);
		host.sel(1'b0);
		chk(dac_code, d);
		// Continuous conversions; a start-marked byte then returns to single mode.
		v = 10'($urandom_range(255));
		@(posedge clk) analog_input_code <= v;
		@(negedge clk);
		host.sel(1'b1);
		host.shift(8, 8'hAE);
		for (int i = 0; i < 3; i++) begin
			wait_th(1'b1);
			wait_th(1'b0);
			exp_q.push_back(clamp(v));
			v = 10'($urandom_range(255));
			@(posedge clk) analog_input_code <= v;
			@(negedge clk);
			host.shift(8, (i == 1) ? 8'hA6 : 8'h00);
		end
		host.sel(1'b0);
		chk(track_hold, 1'b0);
		host.sel(1'b1);
		host.shift(3, 8'h05);
		host.sel(1'b0);
		repeat (4) @(negedge clk);
		chk({dac_code, dac_power, adc_power, ref_power}, 16'h0000);
		chk(16'(exp_q.size()), 16'h0000);
		tally_and_finish();
	end

	// Watchdog: the sequence needs about an eighth of this span.
	initial begin
		#100000;
		err_count++;
		tally_and_finish();
	end
endmodule : tb_top

bind csc_serial_control csc_serial_control_asserts #(.CONV_CYCLES(CONV_CYCLES)) u_asserts (
	.clk(clk),
	.reset(reset),
	.sclk(sclk),
	.cs_n(cs_n),
	.serial_in(serial_in),
	.analog_input_code(analog_input_code),
	.half_supply_code(half_supply_code),
	.serial_out(serial_out),
	.serial_out_en(serial_out_en),
	.track_hold(track_hold),
	.dac_code(dac_code),
	.dac_power(dac_power),
	.adc_power(adc_power),
	.ref_power(ref_power),
	.supply_sense_select(supply_sense_select)
);
